// ---- hdl/stcac_pkg.sv ----
/*
 * Package for the absolute-time compare unit: register offsets, field layout,
 * reset values and timing constants.
 * Assumes a 32-bit APB slave at 50 MHz.
 */
package stcac_pkg;
	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] STCAC_OFF_CMP_LOW   = 8'h00;
	localparam logic [7:0] STCAC_OFF_CMP_HIGH  = 8'h04;
	localparam logic [7:0] STCAC_OFF_MSK_LOW   = 8'h08;
	localparam logic [7:0] STCAC_OFF_MSK_HIGH  = 8'h0C;
	localparam logic [7:0] STCAC_OFF_CTRL      = 8'h10;
	localparam logic [7:0] STCAC_OFF_STATUS    = 8'h14;
	localparam logic [7:0] STCAC_OFF_INIT_LOW  = 8'h18;
	localparam logic [7:0] STCAC_OFF_INIT_HIGH = 8'h1C;
	localparam logic [7:0] STCAC_OFF_TIME_LOW  = 8'h20;
	localparam logic [7:0] STCAC_OFF_TIME_HIGH = 8'h24;

	// ************************************************************
	// Fields and reset values
	// ************************************************************
	localparam int STCAC_TIME_W       = 33;
	localparam int STCAC_HIGH_BIT     = 0;
	localparam int STCAC_CTRL_EN_BIT  = 0;
	localparam int STCAC_STAT_HIT_BIT = 0;
	localparam logic [31:0] STCAC_RST_WORD = 32'h0000_0000;
	localparam logic [32:0] STCAC_RST_TIME = 33'h0_0000_0000;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int STCAC_CLK_HZ  = 50_000_000;
	localparam int STCAC_TICK_HZ = 90_000;
	localparam int STCAC_TICK_CYC = STCAC_CLK_HZ / STCAC_TICK_HZ;
	localparam logic [9:0] STCAC_TICK_LAST = 10'(STCAC_TICK_CYC - 1);
endpackage

// ---- hdl/stcac_top.sv ----
/*
 * Absolute-time compare unit with its 33-bit time base and APB register file.
 * Assumes a single 50 MHz clock and an APB master of the usual two-phase kind.
 */
`timescale 1ns/10ps
module stcac_top
	import stcac_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             time_match_flag
);
	// ************************************************************
	// Bus decode
	// ************************************************************
	logic        wr_en;
	logic        rd_en;
	logic        hit_map;
	logic [32:0] cmp_r;
	logic [32:0] msk_r;
	logic [32:0] stc_r;
	logic        time_irq_enable_r;
	logic [9:0]  div_r;
	logic        tick;
	logic        tick_d_r;
	logic        match;
	logic        flag_clr;
	logic [31:0] rd_nxt;

	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;
	always_comb begin
		case (paddr)
			STCAC_OFF_CMP_LOW, STCAC_OFF_CMP_HIGH, STCAC_OFF_MSK_LOW,
			STCAC_OFF_MSK_HIGH, STCAC_OFF_CTRL, STCAC_OFF_STATUS,
			STCAC_OFF_INIT_LOW, STCAC_OFF_INIT_HIGH, STCAC_OFF_TIME_LOW,
			STCAC_OFF_TIME_HIGH: hit_map = 1'b1;
			default: hit_map = 1'b0;
		endcase
	end

	// ************************************************************
	// Compare, mask and control registers
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_r <= STCAC_RST_TIME;
			msk_r <= STCAC_RST_TIME;
			time_irq_enable_r <= 1'b0;
		end else if (wr_en) begin
			case (paddr)
				STCAC_OFF_CMP_LOW:  cmp_r[31:0] <= pwdata;
				STCAC_OFF_CMP_HIGH: cmp_r[32] <= pwdata[STCAC_HIGH_BIT];
				STCAC_OFF_MSK_LOW:  msk_r[31:0] <= pwdata;
				STCAC_OFF_MSK_HIGH: msk_r[32] <= pwdata[STCAC_HIGH_BIT];
				STCAC_OFF_CTRL:     time_irq_enable_r <= pwdata[STCAC_CTRL_EN_BIT];
				default: ;
			endcase
		end
	end

	// ************************************************************
	// Time base
	// ************************************************************
	// Divider rounds down, so the rate runs a little fast of 90 kHz
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 10'h000;
		end else if (div_r == STCAC_TICK_LAST) begin
			div_r <= 10'h000;
		end else begin
			div_r <= div_r + 10'h001;
		end
	end
	assign tick = (div_r == STCAC_TICK_LAST);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stc_r <= STCAC_RST_TIME;
		end else if (wr_en && paddr == STCAC_OFF_INIT_LOW) begin
			stc_r <= {stc_r[32], pwdata};
		end else if (wr_en && paddr == STCAC_OFF_INIT_HIGH) begin
			stc_r <= {pwdata[STCAC_HIGH_BIT], stc_r[31:0]};
		end else if (tick) begin
			stc_r <= stc_r + 33'h0_0000_0001;
		end
	end

	// ************************************************************
	// Match detection
	// ************************************************************
	// Compare one cycle after each counter update, loads included
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_d_r <= 1'b0;
		end else begin
			tick_d_r <= tick | (wr_en & (paddr == STCAC_OFF_INIT_LOW
				| paddr == STCAC_OFF_INIT_HIGH));
		end
	end
	assign match = tick_d_r & time_irq_enable_r
		& (((cmp_r ^ stc_r) & ~msk_r) == 33'h0_0000_0000);
	// Write one to clear; a coincident match still wins
	assign flag_clr = wr_en & (paddr == STCAC_OFF_STATUS) & pwdata[STCAC_STAT_HIT_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			time_match_flag <= 1'b0;
		end else if (match) begin
			time_match_flag <= 1'b1;
		end else if (flag_clr) begin
			time_match_flag <= 1'b0;
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************
	always_comb begin
		rd_nxt = STCAC_RST_WORD;
		case (paddr)
			STCAC_OFF_CMP_LOW:   rd_nxt = cmp_r[31:0];
			STCAC_OFF_CMP_HIGH:  rd_nxt = {31'h0000_0000, cmp_r[32]};
			STCAC_OFF_MSK_LOW:   rd_nxt = msk_r[31:0];
			STCAC_OFF_MSK_HIGH:  rd_nxt = {31'h0000_0000, msk_r[32]};
			STCAC_OFF_CTRL:      rd_nxt = {31'h0000_0000, time_irq_enable_r};
			STCAC_OFF_STATUS:    rd_nxt = {31'h0000_0000, time_match_flag};
			STCAC_OFF_TIME_LOW:  rd_nxt = stc_r[31:0];
			STCAC_OFF_TIME_HIGH: rd_nxt = {31'h0000_0000, stc_r[32]};
			default:             rd_nxt = STCAC_RST_WORD;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= STCAC_RST_WORD;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit_map;
			if (rd_en) begin
				prdata <= rd_nxt;
			end
		end
	end
endmodule // stcac_top

// ---- verif/stcac_asserts.sv ----
/* Port checker for stcac_top.
   Bound from the testbench; one clock domain. */
`timescale 1ns/10ps
module stcac_asserts
	import stcac_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        time_match_flag
);
	// ****
	// Checks
	// ****
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire setup = psel && !penable;
	wire clr = psel && penable && pwrite && paddr == STCAC_OFF_STATUS && pwdata[0];
	wire hrd = pready && !pwrite && (paddr == STCAC_OFF_CMP_HIGH || paddr == STCAC_OFF_MSK_HIGH);
	a_ready_after_setup: assert property (setup |=> pready) else $error("no ready");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("long ready");
	a_ready_has_cause: assert property (pready |-> $past(setup)) else $error("stray ready");
	a_err_unmapped: assert property (setup && paddr > 8'h27 |=> pslverr) else $error("no err");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("lone err");
	a_high_reads_zero: assert property (hrd |-> prdata[31:1] == 31'h0000_0000)
		else $error("high bits set");
	a_read_data_hold: assert property (!(setup && !pwrite) |=> $stable(prdata))
		else $error("read data moved");
	a_flag_sticky: assert property ($fell(time_match_flag) |-> $past(clr))
		else $error("flag dropped");
	c_match: cover property ($rose(time_match_flag));
	c_err: cover property (pslverr);
	c_high: cover property (hrd);
endmodule // stcac_asserts

// ---- verif/testbench.sv ----
/* Self-checking bench for stcac_top.
   Drives the APB ports itself; no far-side model. */
`timescale 1ns/10ps
module testbench
	import stcac_pkg::*;
;
	// ****
	// Bench
	// ****
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic        pready, pslverr, time_match_flag, er;
	int          mismatches = 0, checks_done = 0;
	always #10 pclk = ~pclk;
	stcac_top dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .time_match_flag(time_match_flag));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk) penable <= 1'h1;
		// No fixed latency assumed; the watchdog ends a stuck wait
		do @(posedge pclk); while (pready !== 1'h1);
		chk("pready", {31'h0000_0000, pready}, 32'h0000_0001);
		rd = prdata; er = pslverr;
		psel <= 1'h0; penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic t_regs();
		logic [7:0] offs[4] = '{STCAC_OFF_CMP_LOW, STCAC_OFF_CMP_HIGH,
			STCAC_OFF_MSK_LOW, STCAC_OFF_MSK_HIGH};
		foreach (offs[i]) begin
			apb(0, offs[i], 0); chk("reset word", rd, STCAC_RST_WORD);
			apb(1, offs[i], 32'hFFFF_FFFF); apb(0, offs[i], 0);
			chk("written word", rd, offs[i][2] ? 32'h0000_0001 : 32'hFFFF_FFFF);
			apb(1, offs[i], 0);
		end
		apb(1, 8'h40, 32'h0000_0001); chk("pslverr", {31'h0000_0000, er}, 32'h0000_0001);
		apb(0, 8'h40, 0);
		chk("unmapped read", rd, STCAC_RST_WORD);
		chk("unmapped err", {31'h0000_0000, er}, 32'h0000_0001);
	endtask
	task automatic t_match();
		// Enable off while loading values
		apb(1, STCAC_OFF_CTRL, 0); apb(1, STCAC_OFF_CMP_LOW, 32'h0000_0005);
		apb(1, STCAC_OFF_INIT_HIGH, 0); apb(1, STCAC_OFF_INIT_LOW, 32'h0000_0004);
		apb(1, STCAC_OFF_STATUS, 1); apb(1, STCAC_OFF_CTRL, 1);
		chk("flag early", {31'h0000_0000, time_match_flag}, 0);
		for (int n = 0; n < 700 && time_match_flag !== 1'h1; n++) @(posedge pclk);
		repeat (10) @(posedge pclk);
		chk("flag on match", {31'h0000_0000, time_match_flag}, 1);
		apb(1, STCAC_OFF_STATUS, 1); apb(1, STCAC_OFF_CTRL, 0);
		apb(1, STCAC_OFF_MSK_LOW, 32'hFFFF_FFFF); apb(1, STCAC_OFF_MSK_HIGH, 1);
		apb(1, STCAC_OFF_INIT_LOW, 32'h0000_0064); repeat (3) @(posedge pclk);
		chk("flag disabled", {31'h0000_0000, time_match_flag}, 0);
		apb(1, STCAC_OFF_CTRL, 1); apb(1, STCAC_OFF_INIT_LOW, 32'h0000_0064);
		repeat (3) @(posedge pclk);
		chk("flag masked", {31'h0000_0000, time_match_flag}, 1);
	endtask
	task automatic t_reset();
		// Reset in mid-run must bring the flag, the low compare word and both mask words back to zero
		apb(1, STCAC_OFF_CMP_LOW, 32'hFFFF_FFFF);
		presetn <= 1'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		chk("flag after reset", {31'h0000_0000, time_match_flag}, 0);
		apb(0, STCAC_OFF_CMP_LOW, 0); chk("cmp low reset", rd, STCAC_RST_WORD);
		apb(0, STCAC_OFF_MSK_LOW, 0); chk("mask low reset", rd, STCAC_RST_WORD);
		apb(0, STCAC_OFF_MSK_HIGH, 0); chk("mask high reset", rd, STCAC_RST_WORD);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_regs();
		t_match();
		t_reset();
		give_verdict();
	end
	initial begin
		#200us;
		mismatches++;
		give_verdict();
	end
endmodule // testbench
bind stcac_top stcac_asserts u_chk(.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .time_match_flag(time_match_flag));
